/* gpio_fgh_map.vh */
`ifndef GPIO_FGH_MAP_VH
`define GPIO_FGH_MAP_VH
// Operation
// - Direction one drives pin, zero makes input
// - Reset clears port F direction bits
// - Reset clears port G direction bits
// - Reset clears port H direction bits
// - Reset leaves port G/H latches untouched
// - Reset leaves port F latches untouched
// - Port F read: latch if output, else pin
// - Port G read: latch if output, else pin
// - Port H read: latch if output, else pin
// - Data writes always update latches
// - Timer-owned F pins ignore direction for drive
// - F pins 0-3 go to timer A
// - F pins 4-5 go to timer B
// - Keypad enable overrides port G direction for drive
// - Keypad enables 3-4 take port H pins
// - G has three pins, H two, keypad-shared

// Register indices; byte address is four times the index
`define IDX_PORT_F_PIN_DATA 4'h9
`define IDX_PORT_G_PIN_DATA 4'hA
`define IDX_PORT_H_PIN_DATA 4'hB
`define IDX_PORT_F_DIRECTION 4'hC
`define IDX_PORT_G_DIRECTION 4'hD
`define IDX_PORT_H_DIRECTION 4'hE
`define INDEX_LSB 2
`define INDEX_MSB 5
// Widths
`define PORT_F_WIDTH 7
`define PORT_G_WIDTH 3
`define PORT_H_WIDTH 2
`define KEYPAD_WIDTH 5
// Reset values of direction registers
`define PORT_F_DIR_RESET 7'h00
`define PORT_G_DIR_RESET 3'h0
`define PORT_H_DIR_RESET 2'h0
`endif

/* pin_sync.v */
`timescale 1ns/10ps
`default_nettype none
module pin_sync
#(
   parameter WIDTH = 1
)
(
   // Clock and reset
   input wire clk_sys,
   input wire rstn,
   // Data
   input wire [WIDTH-1:0] async,
   output reg [WIDTH-1:0] synced
);
   reg [WIDTH-1:0] stage;

   // Second stage alone reads the first
   always @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
      begin
         stage <= {WIDTH{1'b0}};
         synced <= {WIDTH{1'b0}};
      end
      else
      begin
         stage <= async;
         synced <= stage;
      end
   end
endmodule // pin_sync
`default_nettype wire

/* gpio_port.v */
`timescale 1ns/10ps
`default_nettype none
module gpio_port
#(
   parameter WIDTH = 1
)
(
   // Clock and reset
   input wire clk_sys,
   input wire rstn,
   // Register writes
   input wire dataWrite,
   input wire dirWrite,
   input wire [WIDTH-1:0] wdata,
   // Takeover by a peer unit
   input wire [WIDTH-1:0] peerOwn,
   input wire [WIDTH-1:0] peerOe,
   input wire [WIDTH-1:0] peerOut,
   // Pins
   input wire [WIDTH-1:0] pinIn,
   output wire [WIDTH-1:0] pinOut,
   output wire [WIDTH-1:0] pinOe,
   // Register view
   output wire [WIDTH-1:0] dataRead,
   output wire [WIDTH-1:0] direction
);
   reg [WIDTH-1:0] latch;
   reg [WIDTH-1:0] dir;
   wire [WIDTH-1:0] pinSync;

   // Latch has no reset: contents stay as they were
   always @(posedge clk_sys)
   begin
      if (dataWrite)
         latch <= wdata;
   end

   always @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
         dir <= {WIDTH{1'b0}};
      else if (dirWrite)
         dir <= wdata;
   end

   pin_sync #(.WIDTH(WIDTH)) u_sync
   (
      .clk_sys(clk_sys),
      .rstn(rstn),
      .async(pinIn),
      .synced(pinSync)
   );

   // Peer owns drive; direction still picks the read source
   assign pinOe = (peerOwn & peerOe) | (~peerOwn & dir);
   assign pinOut = (peerOwn & peerOut) | (~peerOwn & latch);
   assign dataRead = (dir & latch) | (~dir & pinSync);
   assign direction = dir;
endmodule // gpio_port
`default_nettype wire

/* gpio_ports_f_g_h.v */
`timescale 1ns/10ps
`default_nettype none
`include "gpio_fgh_map.vh"
module gpio_ports_f_g_h
(
   // Clock and reset
   input wire clk_sys,
   input wire rstn,
   // AHB-Lite slave
   input wire hsel,
   input wire [31:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [2:0] hsize,
   input wire [31:0] hwdata,
   input wire hready,
   output wire hreadyout,
   output wire hresp,
   output reg [31:0] hrdata,
   // Timer A channel takeover, port F pins 0-3
   input wire [3:0] timerAOwn,
   input wire [3:0] timerAOe,
   input wire [3:0] timerAOut,
   // Timer B channel takeover, port F pins 4-5
   input wire [1:0] timerBOwn,
   input wire [1:0] timerBOe,
   input wire [1:0] timerBOut,
   // Keypad interrupt enables, bits 2:0 port G, 4:3 port H
   input wire [4:0] keypadInterruptEnables,
   output wire [4:0] keypadWakePins,
   // Port F pins
   input wire [6:0] portFIn,
   output wire [6:0] portFOut,
   output wire [6:0] portFOe,
   // Port G pins
   input wire [2:0] portGIn,
   output wire [2:0] portGOut,
   output wire [2:0] portGOe,
   // Port H pins
   input wire [1:0] portHIn,
   output wire [1:0] portHOut,
   output wire [1:0] portHOe
);
   ////////////////////////////////////////////////////////////////////////////
   reg wrPending;
   reg [3:0] wrIndex;
   wire [3:0] rdIndex;
   wire accept;
   wire [6:0] fRead;
   wire [6:0] fDir;
   wire [2:0] gRead;
   wire [2:0] gDir;
   wire [1:0] hRead;
   wire [1:0] hDir;
   wire [6:0] fOwn;
   wire [6:0] fPeerOe;
   wire [6:0] fPeerOut;
   wire [2:0] gSync;
   wire [1:0] hSync;
   reg [31:0] next_hrdata;

   // Zero wait states, always OKAY
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign accept = hsel & htrans[1] & hready;
   assign rdIndex = haddr[`INDEX_MSB:`INDEX_LSB];

   always @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
      begin
         wrPending <= 1'b0;
         wrIndex <= 4'h0;
      end
      else
      begin
         wrPending <= accept & hwrite;
         wrIndex <= rdIndex;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Bit 6 of port F is plain GPIO, no peer
   assign fOwn = {1'b0, timerBOwn, timerAOwn};
   assign fPeerOe = {1'b0, timerBOe, timerAOe};
   assign fPeerOut = {1'b0, timerBOut, timerAOut};

   gpio_port #(.WIDTH(`PORT_F_WIDTH)) u_port_f
   (
      .clk_sys(clk_sys),
      .rstn(rstn),
      .dataWrite(wrPending && wrIndex == `IDX_PORT_F_PIN_DATA),
      .dirWrite(wrPending && wrIndex == `IDX_PORT_F_DIRECTION),
      .wdata(hwdata[6:0]),
      .peerOwn(fOwn),
      .peerOe(fPeerOe),
      .peerOut(fPeerOut),
      .pinIn(portFIn),
      .pinOut(portFOut),
      .pinOe(portFOe),
      .dataRead(fRead),
      .direction(fDir)
   );

   // Keypad owns the pin as an input: drive is off
   gpio_port #(.WIDTH(`PORT_G_WIDTH)) u_port_g
   (
      .clk_sys(clk_sys),
      .rstn(rstn),
      .dataWrite(wrPending && wrIndex == `IDX_PORT_G_PIN_DATA),
      .dirWrite(wrPending && wrIndex == `IDX_PORT_G_DIRECTION),
      .wdata(hwdata[2:0]),
      .peerOwn(keypadInterruptEnables[2:0]),
      .peerOe(3'h0),
      .peerOut(3'h0),
      .pinIn(portGIn),
      .pinOut(portGOut),
      .pinOe(portGOe),
      .dataRead(gRead),
      .direction(gDir)
   );

   gpio_port #(.WIDTH(`PORT_H_WIDTH)) u_port_h
   (
      .clk_sys(clk_sys),
      .rstn(rstn),
      .dataWrite(wrPending && wrIndex == `IDX_PORT_H_PIN_DATA),
      .dirWrite(wrPending && wrIndex == `IDX_PORT_H_DIRECTION),
      .wdata(hwdata[1:0]),
      .peerOwn(keypadInterruptEnables[4:3]),
      .peerOe(2'h0),
      .peerOut(2'h0),
      .pinIn(portHIn),
      .pinOut(portHOut),
      .pinOe(portHOe),
      .dataRead(hRead),
      .direction(hDir)
   );

   // Separate synchronisers for the keypad so it sees live pins
   pin_sync #(.WIDTH(`KEYPAD_WIDTH)) u_kbd_sync
   (
      .clk_sys(clk_sys),
      .rstn(rstn),
      .async({portHIn, portGIn}),
      .synced({hSync, gSync})
   );
   assign keypadWakePins = {hSync, gSync} & keypadInterruptEnables;

   ////////////////////////////////////////////////////////////////////////////
   // Read data captured at address phase, shown in data phase
   always @*
   begin
      next_hrdata = 32'h00000000;
      case (rdIndex)
         `IDX_PORT_F_PIN_DATA: next_hrdata = {25'h0000000, fRead};
         `IDX_PORT_G_PIN_DATA: next_hrdata = {29'h00000000, gRead};
         `IDX_PORT_H_PIN_DATA: next_hrdata = {30'h00000000, hRead};
         `IDX_PORT_F_DIRECTION: next_hrdata = {25'h0000000, fDir};
         `IDX_PORT_G_DIRECTION: next_hrdata = {29'h00000000, gDir};
         `IDX_PORT_H_DIRECTION: next_hrdata = {30'h00000000, hDir};
         default: next_hrdata = 32'h00000000;
      endcase
   end

   always @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
         hrdata <= 32'h00000000;
      else if (accept && !hwrite)
         hrdata <= next_hrdata;
   end
endmodule // gpio_ports_f_g_h
`default_nettype wire

/* gpio_fgh_monitor.sv */
`timescale 1ns/10ps
`default_nettype none
module gpio_fgh_monitor
(
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rstn,
   // Watched ports
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic [3:0] timerAOwn,
   input wire logic [3:0] timerAOe,
   input wire logic [1:0] timerBOwn,
   input wire logic [1:0] timerBOe,
   input wire logic [4:0] keypadInterruptEnables,
   input wire logic [4:0] keypadWakePins,
   input wire logic [2:0] portGIn,
   input wire logic [1:0] portHIn,
   input wire logic [6:0] portFOe,
   input wire logic [2:0] portGOe,
   input wire logic [1:0] portHOe
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rstn);
   AST_READY: assert property (hreadyout && !hresp)
      else $error("bus stall or error response");
   AST_FDIR_RST: assert property ($rose(rstn) && !timerAOwn && !timerBOwn |-> !portFOe)
      else $error("port F drives after reset");
   AST_GDIR_RST: assert property ($rose(rstn) |-> !portGOe)
      else $error("port G drives after reset");
   AST_HDIR_RST: assert property ($rose(rstn) |-> !portHOe)
      else $error("port H drives after reset");
   AST_TIMER_A_UNIT: assert property (((portFOe[3:0] ^ timerAOe) & timerAOwn) == 4'h0)
      else $error("timer A pin enable wrong");
   AST_TIMER_B_UNIT: assert property (((portFOe[5:4] ^ timerBOe) & timerBOwn) == 2'h0)
      else $error("timer B pin enable wrong");
   AST_KEYG: assert property ((portGOe & keypadInterruptEnables[2:0]) == 3'h0)
      else $error("keypad G pin driven");
   AST_KEYH: assert property ((portHOe & keypadInterruptEnables[4:3]) == 2'h0)
      else $error("keypad H pin driven");
   // Two-flop pin path, so enables must be steady for the window
   AST_WAKE: assert property ($past(rstn, 2) && $stable(keypadInterruptEnables)
      && $past(keypadInterruptEnables) == $past(keypadInterruptEnables, 2)
      |-> keypadWakePins == ($past({portHIn, portGIn}, 2) & keypadInterruptEnables))
      else $error("wake pins wrong");
endmodule // gpio_fgh_monitor
bind gpio_ports_f_g_h gpio_fgh_monitor mon (.clk_sys, .rstn, .hreadyout, .hresp, .timerAOwn, .timerAOe,
   .timerBOwn, .timerBOe, .keypadInterruptEnables, .keypadWakePins, .portGIn, .portHIn, .portFOe, .portGOe, .portHOe);
`default_nettype wire

/* gpio_pin_env.sv */
`timescale 1ns/10ps
`default_nettype none
module gpio_pin_env
#(
   parameter W = 1
)
(
   // Design side
   input wire logic [W-1:0] drv,
   input wire logic [W-1:0] oe,
   // Outside source and wire level
   input wire logic [W-1:0] ext,
   output logic [W-1:0] lvl
);
   // Undriven bits follow the outside source, never a stale drive
   assign lvl = (oe & drv) | (~oe & ext);
endmodule // gpio_pin_env
`default_nettype wire

/* tb.sv */
`timescale 1ns/10ps
`default_nettype none
`include "gpio_fgh_map.vh"
module tb;
   typedef struct {logic [1:0] p; logic [6:0] lat, dir, pin, want;} row_t;
   logic clk_sys, rstn, hsel, hwrite, hreadyout, hresp;
   logic [31:0] haddr, hwdata, hrdata;
   logic [1:0] htrans, timerBOwn, timerBOe, timerBOut, portHIn, portHOut, portHOe, extH;
   logic [2:0] hsize, portGIn, portGOut, portGOe, extG;
   logic [3:0] timerAOwn, timerAOe, timerAOut;
   logic [4:0] kie, wake;
   logic [6:0] portFIn, portFOut, portFOe, extF;
   int num_errors = 0;
   int checks = 0;
   int cyc = 0;
   row_t rows [5] = '{'{2'h0, 7'h55, 7'h0F, 7'h33, 7'h35}, '{2'h0, 7'h7F, 7'h00, 7'h2A, 7'h2A},
      '{2'h1, 7'h05, 7'h06, 7'h03, 7'h05}, '{2'h2, 7'h01, 7'h03, 7'h00, 7'h01}, '{2'h2, 7'h02, 7'h01, 7'h01, 7'h00}};
   gpio_ports_f_g_h dut (.*, .hready(hreadyout), .keypadInterruptEnables(kie), .keypadWakePins(wake));
   gpio_pin_env #(.W(7)) envF (.drv(portFOut), .oe(portFOe), .ext(extF), .lvl(portFIn));
   gpio_pin_env #(.W(3)) envG (.drv(portGOut), .oe(portGOe), .ext(extG), .lvl(portGIn));
   gpio_pin_env #(.W(2)) envH (.drv(portHOut), .oe(portHOe), .ext(extH), .lvl(portHIn));
   ////////////////////////////////////////
   initial
   begin
      clk_sys = 0;
      forever #50 clk_sys = ~clk_sys;
   end
   // A hung bus or lost edge ends here
   always @(posedge clk_sys)
   begin
      cyc <= cyc + 1;
      if (cyc == 3000)
      begin
         num_errors++;
         results;
      end
   end
   ////////////////////////////////////////
   task results;
      $display("checks %0d errors %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp)
      begin
         num_errors++;
         $display("mismatch %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task bus(input logic w, input logic [5:0] a, input logic [31:0] d, output logic [31:0] q);
      @(posedge clk_sys);
      hsel <= 1'b1;
      haddr <= {26'h0, a};
      htrans <= 2'h2;
      hwrite <= w;
      do @(posedge clk_sys); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clk_sys); while (hreadyout !== 1'b1);
      q = hrdata;
   endtask
   ////////////////////////////////////////
   initial
   begin
      logic [31:0] q;
      row_t r;
      rstn = 0;
      hsize = 3'h2;
      {hsel, hwrite, haddr, htrans, hwdata} = 0;
      {timerAOwn, timerAOe, timerAOut, timerBOwn, timerBOe, timerBOut, kie} = 0;
      {extF, extG, extH} = 0;
      repeat (10) @(posedge clk_sys);
      rstn <= 1'b1;
      foreach (rows[i])
      begin
         r = rows[i];
         bus(1, {`IDX_PORT_F_PIN_DATA + r.p, 2'h0}, r.lat, q);
         bus(1, {`IDX_PORT_F_DIRECTION + r.p, 2'h0}, r.dir, q);
         extF <= r.p == 0 ? r.pin : extF;
         extG <= r.p == 1 ? r.pin[2:0] : extG;
         extH <= r.p == 2 ? r.pin[1:0] : extH;
         repeat (3) @(posedge clk_sys);
         bus(0, {`IDX_PORT_F_PIN_DATA + r.p, 2'h0}, 0, q);
         chk(q, r.want);
         bus(0, {`IDX_PORT_F_DIRECTION + r.p, 2'h0}, 0, q);
         chk(q, r.dir);
         chk(r.p == 0 ? portFOe : r.p == 1 ? portGOe : portHOe, r.dir);
         chk(r.p == 0 ? portFOut : r.p == 1 ? portGOut : portHOut, r.lat);
         $display("row %0d done", i);
      end
      // Latch write on an input pin, then output enabled after it
      bus(1, 6'h24, 32'h0C, q);
      bus(0, 6'h24, 0, q);
      chk(q, 32'h2A);
      bus(1, 6'h30, 32'h7F, q);
      bus(0, 6'h24, 0, q);
      chk(q, 32'h0C);
      chk(portFOut, 7'h0C);
      $display("input latch test done");
      timerAOwn <= 4'hF;
      timerAOe <= 4'h5;
      timerBOwn <= 2'h3;
      @(posedge clk_sys);
      @(negedge clk_sys);
      chk(portFOe, 7'h45);
      bus(0, 6'h24, 0, q);
      chk(q, 32'h0C);
      {timerAOwn, timerBOwn} <= 0;
      $display("timer test done");
      bus(1, 6'h34, 32'h7, q);
      bus(1, 6'h38, 32'h3, q);
      kie <= 5'h1F;
      extG <= 3'h5;
      extH <= 2'h2;
      repeat (3) @(posedge clk_sys);
      chk({portHOe, portGOe}, 5'h00);
      chk(wake, 5'h15);
      bus(0, 6'h3C, 0, q);
      chk(q, 32'h0);
      $display("keypad and unmapped test done");
      rstn <= 1'b0;
      repeat (2) @(posedge clk_sys);
      rstn <= 1'b1;
      for (int k = 0; k < 3; k++)
      begin
         bus(0, {`IDX_PORT_F_DIRECTION + k[3:0], 2'h0}, 0, q);
         chk(q, 32'h0);
      end
      bus(1, 6'h30, 32'h7F, q);
      bus(1, 6'h34, 32'h7, q);
      bus(0, 6'h24, 0, q);
      chk(q, 32'h0C);
      bus(0, 6'h28, 0, q);
      chk(q, 32'h5);
      $display("reset test done");
      results;
   end
endmodule // tb
`default_nettype wire
